// [hdl/mii_port_if.sv]
// Purpose: pin bundle between the switch port and the external mac
// Assumes: every two-way pin has value and active-low enable from each driver
// Notes:   resolution of shared pins is done here, designs hold no high impedance
interface mii_port_if;
    logic            dev_tx_clk_o;       // device value on transmit clock pin
    logic            dev_tx_clk_oe_n;    // device drives transmit clock when low
    logic            host_tx_clk_o;      // host value on transmit clock pin
    logic            host_tx_clk_oe_n;   // host drives transmit clock when low
    logic            sw_port_tx_clk;     // resolved transmit / reference clock
    logic            dev_rx_clk_o;       // device value on receive clock pin
    logic            dev_rx_clk_oe_n;    // device drives receive clock when low
    logic            host_rx_clk_o;      // host value on receive clock pin
    logic            host_rx_clk_oe_n;   // host drives receive clock when low
    logic            sw_port_rx_clk;     // resolved receive clock
    logic            sw_port_tx_enable;  // host transmit enable
    logic [3:0]      sw_port_tx_nibble;  // host transmit nibble, bit 3 down to bit 0
    logic            sw_port_tx_error;   // host transmit error
    logic            sw_port_rx_valid;   // device receive data valid
    logic [3:0]      dev_rx_nibble_o;    // device receive nibble value
    logic            dev_rx_b3_oe_n;     // device drives receive bit 3 when low
    logic            strap_pull;         // board pull on receive bit 3
    logic            sw_port_rx_nibble_bit3;  // resolved receive bit 3
    logic [3:0]      sw_port_rx_nibble;  // resolved receive nibble

    // undriven clock pins read low
    assign sw_port_tx_clk = !dev_tx_clk_oe_n ? dev_tx_clk_o :
                            (!host_tx_clk_oe_n ? host_tx_clk_o : 1'b0);
    assign sw_port_rx_clk = !dev_rx_clk_oe_n ? dev_rx_clk_o :
                            (!host_rx_clk_oe_n ? host_rx_clk_o : 1'b0);
    // pull resistor wins only while the device releases the pin
    assign sw_port_rx_nibble_bit3 = !dev_rx_b3_oe_n ? dev_rx_nibble_o[3] : strap_pull;
    assign sw_port_rx_nibble = {sw_port_rx_nibble_bit3, dev_rx_nibble_o[2:0]};

    modport dev (
        output dev_tx_clk_o, dev_tx_clk_oe_n, dev_rx_clk_o, dev_rx_clk_oe_n,
        output sw_port_rx_valid, dev_rx_nibble_o, dev_rx_b3_oe_n,
        input  sw_port_tx_clk, sw_port_rx_clk, sw_port_tx_enable,
        input  sw_port_tx_nibble, sw_port_tx_error, sw_port_rx_nibble_bit3
    );
    modport host (
        output host_tx_clk_o, host_tx_clk_oe_n, host_rx_clk_o, host_rx_clk_oe_n,
        output sw_port_tx_enable, sw_port_tx_nibble, sw_port_tx_error, strap_pull,
        input  sw_port_tx_clk, sw_port_rx_clk, sw_port_rx_valid, sw_port_rx_nibble
    );
endinterface

// [hdl/mii_port_pkg.sv]
// Purpose: shared constants, modes and decoders for both ends of the switch MII port
// Assumes: both ends run on a 200 MHz clock
// Notes:   mode encoding is local to this code base
package mii_port_pkg;
    localparam int CLK_HZ      = 200_000_000;          // own clock rate
    localparam int XTAL_HZ     = 25_000_000;           // crystal timebase outside rmii
    localparam int RMII_REF_HZ = 50_000_000;           // rmii reference clock
    localparam int MII_HALF    = CLK_HZ / XTAL_HZ / 2;       // half period, 25 MHz
    localparam int RMII_HALF   = CLK_HZ / RMII_REF_HZ / 2;   // half period, 50 MHz
    localparam int HALF_W      = 4;                    // width of half-period counters
    localparam int NIB_W       = 4;                    // nibble width
    localparam int BUF_DEPTH   = 2;                    // entries per data buffer
    localparam int TX_SYNC_W   = 12;                   // pins synchronised by the device
    localparam int RX_SYNC_W   = 7;                    // pins synchronised by the host
    localparam logic STRAP_SW_FC_RST = 1'b0;           // switch flow control strap default
    localparam logic STRAP_P1_RST    = 1'b0;           // port 1 force strap default

    typedef enum logic [1:0] {
        MODE_PHY_MII = 2'h0,
        MODE_MAC_MII = 2'h1,
        MODE_SNI     = 2'h2,
        MODE_RMII    = 2'h3
    } port_mode_t;

    // device is the source of the transmit clock
    function automatic logic dev_drives_tx_clk(input port_mode_t m);
        return (m == MODE_PHY_MII) || (m == MODE_SNI);
    endfunction

    // device is the source of the receive clock
    function automatic logic dev_drives_rx_clk(input port_mode_t m);
        return (m == MODE_PHY_MII) || (m == MODE_SNI);
    endfunction
endpackage

// [hdl/switch_mii_port_dev.sv]
// Purpose: switch side of the third-port mii: clocks, straps, reset, power down, nibbles
// Assumes: link pins are asynchronous and reach logic only through two flip-flops
// Notes:   nibbles move on the synchronised rising edge of the link clock

// What this block does
// - port 1 strap high forces flow control
// - power-down input low idles the link side of the port
// - reset input low holds the port in reset
// - device drives transmit clock in phy/sni
// - rmii reference clock comes from the mac
// - device drives receive clock in phy/sni
// - receive bit 3 strap enables switch flow control
// - mac drives enable, nibble, error per nibble
// - receive valid qualifies every presented nibble
// - timing outside rmii from 25 MHz crystal rate
module switch_mii_port_dev
    import mii_port_pkg::*;
#(
    parameter int DIV_HALF = MII_HALF          // half period of the generated clocks
) (
    input  wire logic              clock,                       // 200 MHz clock
    input  wire logic              sys_rst,                     // synchronous reset, high
    mii_port_if.dev                link,                        // pins toward the mac
    input  wire port_mode_t        mode,                        // interface mode
    input  wire logic              chip_reset_n,                // hardware reset pin
    input  wire logic              chip_power_down_n,           // power-down pin
    input  wire logic              port1_force_flow_ctrl_strap, // port 1 strap pin
    input  wire logic              port1_an_flow_ctrl,          // negotiated flow control
    output logic                   port1_flow_ctrl_en,          // port 1 flow control on
    output logic                   sw_flow_ctrl_en,             // switch mii flow control on
    output logic                   chip_active,                 // out of reset and powered
    output logic [NIB_W-1:0]       tx_data,                     // received transmit nibble
    output logic                   tx_err,                      // error flag of that nibble
    output logic                   tx_valid,                    // tx_data holds a nibble
    input  wire logic              tx_ready,                    // user takes the nibble
    output logic                   tx_overrun,                  // nibble lost, full buffer
    input  wire logic [NIB_W-1:0]  rx_data,                     // nibble to send to mac
    input  wire logic              rx_valid_in,                 // rx_data is valid
    output logic                   rx_ready                     // buffer can accept
);
    localparam int PTR_W = $clog2(BUF_DEPTH);
    localparam int CNT_W = $clog2(BUF_DEPTH + 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(BUF_DEPTH);
    localparam logic [HALF_W-1:0] HALF_LAST = HALF_W'(DIV_HALF - 1);

    logic [TX_SYNC_W-1:0] meta_r;
    logic [TX_SYNC_W-1:0] sync_r;
    logic                 rst_n_s;
    logic                 pd_n_s;
    logic                 p1_strap_s;
    logic                 txclk_s;
    logic                 rxclk_s;
    logic                 b3_s;
    logic                 txen_s;
    logic                 txerr_s;
    logic [NIB_W-1:0]     txnib_s;
    logic                 in_reset;
    logic                 active;
    logic                 p1_strap_r;
    logic                 sw_fc_strap_r;
    logic [HALF_W-1:0]    half_r;
    logic                 gen_clk_r;
    logic                 txclk_d_r;
    logic                 rxclk_d_r;
    logic                 tx_edge;
    logic                 rx_edge;
    logic                 rx_src_s;
    logic                 rx_src_d;
    logic [NIB_W:0]       tx_mem [BUF_DEPTH];
    logic [PTR_W-1:0]     tx_wp_r;
    logic [PTR_W-1:0]     tx_rp_r;
    logic [CNT_W-1:0]     tx_cnt_r;
    logic                 tx_push;
    logic                 tx_pop;
    logic [NIB_W-1:0]     rx_mem [BUF_DEPTH];
    logic [PTR_W-1:0]     rx_wp_r;
    logic [PTR_W-1:0]     rx_rp_r;
    logic [CNT_W-1:0]     rx_cnt_r;
    logic                 rx_push;
    logic                 rx_pop;
    logic                 rx_valid_r;
    logic [NIB_W-1:0]     rx_nib_r;
    logic                 overrun_r;

    // two-flop synchroniser for every pin that enters from outside
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= {chip_reset_n, chip_power_down_n, port1_force_flow_ctrl_strap,
                       link.sw_port_tx_clk, link.sw_port_rx_clk, link.sw_port_rx_nibble_bit3,
                       link.sw_port_tx_enable, link.sw_port_tx_error, link.sw_port_tx_nibble};
            sync_r <= meta_r;
        end
    end
    assign {rst_n_s, pd_n_s, p1_strap_s, txclk_s, rxclk_s, b3_s,
            txen_s, txerr_s, txnib_s} = sync_r;

    // reset pin holds everything, power-down stops the link but keeps straps
    assign in_reset    = sys_rst || !rst_n_s;
    assign active      = !in_reset && pd_n_s;
    assign chip_active = active;

    // straps follow their pins during reset and freeze at release
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            p1_strap_r    <= STRAP_P1_RST;
            sw_fc_strap_r <= STRAP_SW_FC_RST;
        end else if (!rst_n_s) begin
            p1_strap_r    <= p1_strap_s;
            sw_fc_strap_r <= b3_s;
        end
    end

    // flow control enables; a forced port ignores negotiation
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            port1_flow_ctrl_en <= 1'b0;
            sw_flow_ctrl_en    <= 1'b0;
        end else begin
            port1_flow_ctrl_en <= p1_strap_r || port1_an_flow_ctrl;
            sw_flow_ctrl_en    <= sw_fc_strap_r;
        end
    end

    // 25 MHz timebase divided from the own clock, stopped while idle
    always_ff @(posedge clock) begin
        if (sys_rst || !active) begin
            half_r    <= '0;
            gen_clk_r <= 1'b0;
        end else if (half_r == HALF_LAST) begin
            half_r    <= '0;
            gen_clk_r <= !gen_clk_r;
        end else begin
            half_r <= half_r + HALF_W'(1);
        end
    end

    // clock pin direction by mode; pins released during reset
    always_comb begin
        link.dev_tx_clk_o    = gen_clk_r;
        link.dev_tx_clk_oe_n = in_reset || !dev_drives_tx_clk(mode);
        link.dev_rx_clk_o    = gen_clk_r;
        link.dev_rx_clk_oe_n = in_reset || !dev_drives_rx_clk(mode);
    end

    // edges read back from the pins, so own and foreign clocks look alike;
    // in rmii the reference on the transmit pin times both directions
    assign rx_src_s = (mode == MODE_RMII) ? txclk_s : rxclk_s;
    assign rx_src_d = (mode == MODE_RMII) ? txclk_d_r : rxclk_d_r;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            txclk_d_r <= 1'b0;
            rxclk_d_r <= 1'b0;
        end else begin
            txclk_d_r <= txclk_s;
            rxclk_d_r <= rxclk_s;
        end
    end
    assign tx_edge = active && txclk_s && !txclk_d_r;
    assign rx_edge = active && rx_src_s && !rx_src_d;

    // transmit buffer: the mii cannot be stalled, so a full buffer drops
    assign tx_push  = tx_edge && txen_s;
    assign tx_pop   = tx_valid && tx_ready;
    assign tx_valid = (tx_cnt_r != '0);
    assign {tx_err, tx_data} = tx_mem[tx_rp_r];
    always_ff @(posedge clock) begin
        if (in_reset) begin
            tx_wp_r  <= '0;
            tx_rp_r  <= '0;
            tx_cnt_r <= '0;
        end else begin
            if (tx_push && (tx_cnt_r != CNT_FULL || tx_pop)) begin
                tx_mem[tx_wp_r] <= {txerr_s, txnib_s};
                tx_wp_r         <= tx_wp_r + PTR_W'(1);
            end
            if (tx_pop) begin
                tx_rp_r <= tx_rp_r + PTR_W'(1);
            end
            if ((tx_push && (tx_cnt_r != CNT_FULL || tx_pop)) && !tx_pop) begin
                tx_cnt_r <= tx_cnt_r + CNT_W'(1);
            end else if (tx_pop && !tx_push) begin
                tx_cnt_r <= tx_cnt_r - CNT_W'(1);
            end
        end
    end

    // one-cycle pulse per dropped nibble
    always_ff @(posedge clock) begin
        if (in_reset) begin
            overrun_r <= 1'b0;
        end else begin
            overrun_r <= tx_push && (tx_cnt_r == CNT_FULL) && !tx_pop;
        end
    end
    assign tx_overrun = overrun_r;

    // receive buffer, filled by the user and drained one nibble per link edge
    assign rx_ready = !in_reset && (rx_cnt_r != CNT_FULL);
    assign rx_push  = rx_valid_in && rx_ready;
    assign rx_pop   = rx_edge && (rx_cnt_r != '0);
    always_ff @(posedge clock) begin
        if (in_reset) begin
            rx_wp_r  <= '0;
            rx_rp_r  <= '0;
            rx_cnt_r <= '0;
        end else begin
            if (rx_push) begin
                rx_mem[rx_wp_r] <= rx_data;
                rx_wp_r         <= rx_wp_r + PTR_W'(1);
            end
            if (rx_pop) begin
                rx_rp_r <= rx_rp_r + PTR_W'(1);
            end
            if (rx_push && !rx_pop) begin
                rx_cnt_r <= rx_cnt_r + CNT_W'(1);
            end else if (rx_pop && !rx_push) begin
                rx_cnt_r <= rx_cnt_r - CNT_W'(1);
            end
        end
    end

    // receive pins change only on a link edge, or clear at reset or power-down; valid low marks an empty slot
    always_ff @(posedge clock) begin
        if (in_reset || !pd_n_s) begin
            rx_valid_r <= 1'b0;
            rx_nib_r   <= '0;
        end else if (rx_edge) begin
            rx_valid_r <= rx_pop;
            rx_nib_r   <= rx_pop ? rx_mem[rx_rp_r] : '0;
        end
    end
    // valid falls with the bit 3 release, so no nibble is qualified on the strap pull
    assign link.sw_port_rx_valid = rx_valid_r && !in_reset;
    assign link.dev_rx_nibble_o  = rx_nib_r;
    // bit 3 released while reset holds, so the strap pull can be read
    assign link.dev_rx_b3_oe_n   = in_reset;
endmodule

// [hdl/switch_mii_port_host.sv]
// Purpose: external mac end of the switch mii port
// Assumes: same 200 MHz clock rate as the switch end, asynchronous to it
// Notes:   nibbles launch and land on the synchronised rising edge of the link clock
module switch_mii_port_host
    import mii_port_pkg::*;
#(
    parameter int MII_DIV_HALF  = MII_HALF,    // half period of 25 MHz clocks
    parameter int RMII_DIV_HALF = RMII_HALF    // half period of 50 MHz reference
) (
    input  wire logic              clock,        // 200 MHz clock
    input  wire logic              sys_rst,      // synchronous reset, high
    mii_port_if.host               link,         // pins toward the switch
    input  wire port_mode_t        mode,         // interface mode
    input  wire logic              strap_sw_fc,  // pull level on receive bit 3
    input  wire logic [NIB_W-1:0]  tx_data,      // nibble to transmit
    input  wire logic              tx_err_in,    // error flag for that nibble
    input  wire logic              tx_valid,     // tx_data valid
    output logic                   tx_ready,     // buffer can accept
    output logic [NIB_W-1:0]       rx_data,      // nibble from the switch
    output logic                   rx_valid,     // rx_data holds a nibble
    input  wire logic              rx_ready,     // user takes the nibble
    output logic                   rx_overrun    // nibble lost, full buffer
);
    localparam int PTR_W = $clog2(BUF_DEPTH);
    localparam int CNT_W = $clog2(BUF_DEPTH + 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(BUF_DEPTH);

    logic [RX_SYNC_W-1:0] meta_r;
    logic [RX_SYNC_W-1:0] sync_r;
    logic                 txclk_s;
    logic                 rxclk_s;
    logic                 rxv_s;
    logic [NIB_W-1:0]     rxnib_s;
    logic                 txclk_d_r;
    logic                 rxclk_d_r;
    logic                 tx_edge;
    logic                 rx_edge;
    logic [HALF_W-1:0]    half_r;
    logic [HALF_W-1:0]    half_last;
    logic                 gen_clk_r;
    logic [NIB_W:0]       tx_mem [BUF_DEPTH];
    logic [PTR_W-1:0]     tx_wp_r;
    logic [PTR_W-1:0]     tx_rp_r;
    logic [CNT_W-1:0]     tx_cnt_r;
    logic                 tx_push;
    logic                 tx_pop;
    logic                 txen_r;
    logic [NIB_W-1:0]     txnib_r;
    logic                 txerr_r;
    logic [NIB_W-1:0]     rx_mem [BUF_DEPTH];
    logic [PTR_W-1:0]     rx_wp_r;
    logic [PTR_W-1:0]     rx_rp_r;
    logic [CNT_W-1:0]     rx_cnt_r;
    logic                 rx_push;
    logic                 rx_pop;
    logic                 overrun_r;

    // two-flop synchroniser for the switch pins
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= {link.sw_port_tx_clk, link.sw_port_rx_clk,
                       link.sw_port_rx_valid, link.sw_port_rx_nibble};
            sync_r <= meta_r;
        end
    end
    assign {txclk_s, rxclk_s, rxv_s, rxnib_s} = sync_r;

    // clock divider: 25 MHz in mac mode, 50 MHz reference in rmii
    assign half_last = (mode == MODE_RMII) ? HALF_W'(RMII_DIV_HALF - 1)
                                           : HALF_W'(MII_DIV_HALF - 1);
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            half_r    <= '0;
            gen_clk_r <= 1'b0;
        end else if (half_r >= half_last) begin
            half_r    <= '0;
            gen_clk_r <= !gen_clk_r;
        end else begin
            half_r <= half_r + HALF_W'(1);
        end
    end

    // drive clock pins only where the switch expects them as inputs
    always_comb begin
        link.host_tx_clk_o    = gen_clk_r;
        link.host_tx_clk_oe_n = dev_drives_tx_clk(mode);
        link.host_rx_clk_o    = gen_clk_r;
        link.host_rx_clk_oe_n = (mode != MODE_MAC_MII);
    end
    assign link.strap_pull = strap_sw_fc;

    // edges read back from the pins; rmii uses the reference both ways
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            txclk_d_r <= 1'b0;
            rxclk_d_r <= 1'b0;
        end else begin
            txclk_d_r <= txclk_s;
            rxclk_d_r <= rxclk_s;
        end
    end
    assign tx_edge = txclk_s && !txclk_d_r;
    assign rx_edge = (mode == MODE_RMII) ? tx_edge : (rxclk_s && !rxclk_d_r);

    // transmit buffer, back-pressure reaches the user through tx_ready
    assign tx_ready = !sys_rst && (tx_cnt_r != CNT_FULL);
    assign tx_push  = tx_valid && tx_ready;
    assign tx_pop   = tx_edge && (tx_cnt_r != '0);
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tx_wp_r  <= '0;
            tx_rp_r  <= '0;
            tx_cnt_r <= '0;
        end else begin
            if (tx_push) begin
                tx_mem[tx_wp_r] <= {tx_err_in, tx_data};
                tx_wp_r         <= tx_wp_r + PTR_W'(1);
            end
            if (tx_pop) begin
                tx_rp_r <= tx_rp_r + PTR_W'(1);
            end
            if (tx_push && !tx_pop) begin
                tx_cnt_r <= tx_cnt_r + CNT_W'(1);
            end else if (tx_pop && !tx_push) begin
                tx_cnt_r <= tx_cnt_r - CNT_W'(1);
            end
        end
    end

    // enable, nibble and error launched together on each link edge
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            txen_r  <= 1'b0;
            txnib_r <= '0;
            txerr_r <= 1'b0;
        end else if (tx_edge) begin
            txen_r            <= tx_pop;
            {txerr_r, txnib_r} <= tx_pop ? tx_mem[tx_rp_r] : '0;
        end
    end
    assign link.sw_port_tx_enable = txen_r;
    assign link.sw_port_tx_nibble = txnib_r;
    assign link.sw_port_tx_error  = txerr_r;

    // receive buffer: only valid-qualified nibbles are kept
    assign rx_push  = rx_edge && rxv_s;
    assign rx_pop   = rx_valid && rx_ready;
    assign rx_valid = (rx_cnt_r != '0);
    assign rx_data  = rx_mem[rx_rp_r];
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rx_wp_r   <= '0;
            rx_rp_r   <= '0;
            rx_cnt_r  <= '0;
            overrun_r <= 1'b0;
        end else begin
            overrun_r <= rx_push && (rx_cnt_r == CNT_FULL) && !rx_pop;
            if (rx_push && (rx_cnt_r != CNT_FULL || rx_pop)) begin
                rx_mem[rx_wp_r] <= rxnib_s;
                rx_wp_r         <= rx_wp_r + PTR_W'(1);
            end
            if (rx_pop) begin
                rx_rp_r <= rx_rp_r + PTR_W'(1);
            end
            if (rx_push && (rx_cnt_r != CNT_FULL || rx_pop) && !rx_pop) begin
                rx_cnt_r <= rx_cnt_r + CNT_W'(1);
            end else if (rx_pop && !rx_push) begin
                rx_cnt_r <= rx_cnt_r - CNT_W'(1);
            end
        end
    end
    assign rx_overrun = overrun_r;
endmodule

// [tb/mii_port_monitor.sv]
// Purpose: pin checks on the link between the two port ends
// Assumes: one clock domain
// Notes:   up_r hides the settling after any reset
module mii_port_monitor
    import mii_port_pkg::*;
(
    input wire logic       clock, // clock
    input wire logic       sys_rst, // reset
    input wire port_mode_t mode, // mode
    input wire logic       chip_reset_n, // reset pin
    input wire logic       chip_power_down_n, // power pin
    input wire logic       dev_tx_clk_oe_n, // device tx clk
    input wire logic       dev_rx_clk_oe_n, // device rx clk
    input wire logic       host_tx_clk_oe_n, // host tx clk
    input wire logic       host_rx_clk_oe_n, // host rx clk
    input wire logic       sw_port_tx_clk, // tx clk pin
    input wire logic       sw_port_rx_valid, // rx valid
    input wire logic       dev_rx_b3_oe_n // bit 3 enable
);
    logic [3:0] up_r; // saturating
    // enables lag the pin synchronisers, so directions are judged late
    always_ff @(posedge clock) begin
        if (sys_rst || !chip_reset_n) up_r <= 4'h0;
        else if (!(&up_r)) up_r <= up_r + 4'h1;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    tx_dir_a: assert property (&up_r |-> dev_tx_clk_oe_n == mode[0])
        else $error("tx clock dir");
    rx_dir_a: assert property (&up_r |-> dev_rx_clk_oe_n == mode[0])
        else $error("rx clock dir");
    host_tx_a: assert property (&up_r && mode[0] |-> !host_tx_clk_oe_n)
        else $error("host tx clock");
    host_rx_a: assert property (&up_r && mode == MODE_MAC_MII |-> !host_rx_clk_oe_n)
        else $error("host rx clock");
    rst_hold_a: assert property (!chip_reset_n [*5] |-> dev_tx_clk_oe_n
        && dev_rx_clk_oe_n && dev_rx_b3_oe_n && !sw_port_rx_valid) else $error("reset leak");
    pwr_down_a: assert property (!chip_power_down_n [*5] |-> !sw_port_rx_valid)
        else $error("valid in power down");
    valid_pin_a: assert property (sw_port_rx_valid |-> !dev_rx_b3_oe_n)
        else $error("valid on released pins");
    clk_period_a: assert property (&up_r && !mode[0] && $rose(sw_port_tx_clk)
        |=> (!$rose(sw_port_tx_clk)) [*7]) else $error("tx clock fast");
    cover property (&up_r && mode == MODE_RMII && $rose(sw_port_tx_clk));
    cover property ($fell(sw_port_rx_valid));
    cover property (!chip_power_down_n [*5]);
endmodule

// [tb/tb_switch_mii_port.sv]
// Purpose: both ends joined, random nibbles both ways in every mode
// Assumes: default divider settings
// Notes:   straps flipped after release to show they stay latched
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; \
    $display("BAD %0t %h %h", $time, a, b); end end
module tb_switch_mii_port;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, sys_rst, chip_reset_n, chip_power_down_n, en, e1, e7, a1, a2, a3, a4;
    logic port1_force_flow_ctrl_strap, port1_an_flow_ctrl, port1_flow_ctrl_en;
    logic sw_flow_ctrl_en, chip_active, strap, d_tv, d_tr, d_te, d_rv, d_rr;
    logic h_tv, h_tr, h_te, h_rv, h_rr, d_ov, h_ov;
    logic [3:0] d_td, d_rd, h_td, h_rd;
    logic [4:0] qd[$], qh[$];
    int seed, miscompares, comparisons;
    mii_port_pkg::port_mode_t mode;
    mii_port_if lk ();
    switch_mii_port_dev i_switch_mii_port_dev (.clock, .sys_rst, .link(lk.dev), .mode,
        .chip_reset_n, .chip_power_down_n, .port1_force_flow_ctrl_strap, .port1_an_flow_ctrl,
        .port1_flow_ctrl_en, .sw_flow_ctrl_en, .chip_active, .tx_data(d_td), .tx_err(d_te),
        .tx_valid(d_tv), .tx_ready(d_tr), .tx_overrun(d_ov), .rx_data(d_rd), .rx_valid_in(d_rv),
        .rx_ready(d_rr));
    switch_mii_port_host i_switch_mii_port_host (.clock, .sys_rst, .link(lk.host), .mode,
        .strap_sw_fc(strap), .tx_data(h_td), .tx_err_in(h_te), .tx_valid(h_tv),
        .tx_ready(h_tr), .rx_data(h_rd), .rx_valid(h_rv), .rx_ready(h_rr), .rx_overrun(h_ov));
    mii_port_monitor i_mon (.clock, .sys_rst, .mode, .chip_reset_n, .chip_power_down_n,
        .dev_tx_clk_oe_n(lk.dev_tx_clk_oe_n), .dev_rx_clk_oe_n(lk.dev_rx_clk_oe_n),
        .host_tx_clk_oe_n(lk.host_tx_clk_oe_n), .host_rx_clk_oe_n(lk.host_rx_clk_oe_n),
        .sw_port_tx_clk(lk.sw_port_tx_clk), .sw_port_rx_valid(lk.sw_port_rx_valid),
        .dev_rx_b3_oe_n(lk.dev_rx_b3_oe_n));
    task automatic end_of_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // watchdog at several times the expected run
    initial begin
        #40000;
        miscompares++;
        end_of_test();
    end
    // scoreboard; sources offer every cycle so buffers fill and refuse
    always @(posedge clock) begin
        {a1, a2, a3, a4} = {h_tv & h_tr, d_rv & d_rr, d_tv & d_tr, h_rv & h_rr};
        if (a1) qd.push_back({h_te, h_td});
        if (a2) qh.push_back({1'b0, d_rd});
        if (a3) `CHK({d_te, d_td}, qd[0])
        if (a3) void'(qd.pop_front());
        if (a4) `CHK({1'b0, h_rd}, qh[0])
        if (a4) void'(qh.pop_front());
        // sinks drain faster than the link fills, so no nibble may be dropped
        if (!sys_rst) `CHK({d_ov, h_ov}, 2'h0)
        #1;
        if (a1 || !h_tv) {h_tv, h_te, h_td} = {en, 5'($random(seed))};
        if (a2 || !d_rv) {d_rv, d_rd} = {en, 4'($random(seed))};
        {d_tr, h_rr} = {2'($random(seed)) != 2'h0, 2'($random(seed)) != 2'h0};
    end
    initial begin
        seed = 32'hB4EE;
        {chip_power_down_n, en, port1_an_flow_ctrl} = 3'h4;
        {h_tv, h_te, h_td, d_rv, d_rd, d_tr, h_rr} = 13'h0000;
        for (int m = 0; m < 4; m++) begin
            mode = mii_port_pkg::port_mode_t'(m);
            // every strap combination once, one per mode
            {sys_rst, chip_reset_n, e1, e7} = {2'b10, 2'(m)};
            {port1_force_flow_ctrl_strap, strap} = {e1, e7};
            tick(3);
            sys_rst = 1'b0;
            tick(8);
            `CHK(chip_active, 1'b0)
            `CHK(lk.sw_port_rx_nibble_bit3, e7)
            chip_reset_n = 1'b1;
            tick(6);
            {port1_force_flow_ctrl_strap, strap} = ~{e1, e7};
            port1_an_flow_ctrl = 1'($random(seed));
            tick(2);
            `CHK(port1_flow_ctrl_en, e1 | port1_an_flow_ctrl)
            `CHK(sw_flow_ctrl_en, e7)
            `CHK(chip_active, 1'b1)
            en = 1'b1;
            tick(300);
            en = 1'b0;
            tick(100);
            `CHK(qd.size() + qh.size(), 0)
            chip_power_down_n = 1'b0;
            tick(5);
            `CHK(chip_active, 1'b0)
            chip_power_down_n = 1'b1;
        end
        end_of_test();
    end
endmodule
